// >>> verilog/strap_pins_defs.svh
`ifndef STRAP_PINS_DEFS_SVH
`define STRAP_PINS_DEFS_SVH

// Clock rate and timing.
`define CLK_FREQ_MHZ          200
`define STRAP_SAMPLE_TIME_US  1000
`define STRAP_SAMPLE_CYCLES   (`STRAP_SAMPLE_TIME_US * `CLK_FREQ_MHZ)
`define READY_TIME_MS         125
`define READY_CYCLES          (`READY_TIME_MS * 1000 * `CLK_FREQ_MHZ)
`define WAIT_CNT_W            25

// General-purpose pin layout.
`define GPIO_W                7
`define GPIO_RATE_LSB         0
`define GPIO_RATE_MSB         1
`define GPIO_HOST_MODE        3
`define GPIO_LOW_STRAP        4
`define STRAP_PIN_MASK        7'h0_01B
`define RATE_W                2
`define RATE_RESET            2'h0

// Strap level that selects SPI on the host mode pin.
`define HOST_MODE_SPI_LEVEL   1'h1

// Test port instruction register.
`define IR_W                  4
`define IR_CAPTURE            4'h1
`define IR_BYPASS             4'hF

`endif

// >>> verilog/strap_pins_pkg.sv
package strap_pins_pkg;

  // Host control interface personality.
  typedef enum logic {
    HOST_I2C,
    HOST_SPI
  } host_mode_t;

  // Test access port controller states.
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

endpackage

// >>> verilog/tap_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the synchronised test pins to the TAP and its answers back.
interface tap_link_if;
  import strap_pins_pkg::*;
  logic       clk_en;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       trst_n;
  logic       tdo;
  logic       tdo_oe;
  tap_state_t state;

  modport top (output clk_en, tck, tms, tdi, trst_n, input tdo, tdo_oe, state);
  modport tap (input clk_en, tck, tms, tdi, trst_n, output tdo, tdo_oe, state);
endinterface

`default_nettype wire

// >>> verilog/tap_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "strap_pins_defs.svh"

module tap_controller (
  input  wire logic  clk_in,
  input  wire logic  reset_in,
  tap_link_if.tap    link
);
  import strap_pins_pkg::*;

  tap_state_t       state_q;
  logic             tck_prev_q;
  logic [`IR_W-1:0] ir_shift_q;
  logic [`IR_W-1:0] ir_q;
  logic             bypass_q;
  logic             tdo_q;
  logic             tdo_oe_q;
  logic             tck_rise;
  logic             tck_fall;

  // Standard TAP walk steered by the mode select level.
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    unique case (s)
      TAP_RESET:    tap_next = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:     tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   tap_next = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  // Edges of the sampled test clock; the pins arrive already synchronised.
  assign tck_rise = link.tck & ~tck_prev_q;
  assign tck_fall = ~link.tck & tck_prev_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tck_prev_q <= 1'h0;
    end else if (link.clk_en) begin
      tck_prev_q <= link.tck;
    end
  end

  // State walk; test reset low wins at once, with no test clock edge needed.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= TAP_RESET;
    end else if (link.clk_en) begin
      if (!link.trst_n) begin
        state_q <= TAP_RESET;
      end else if (tck_rise) begin
        state_q <= tap_next(state_q, link.tms);
      end
    end
  end

  // Instruction and bypass paths shift on the rising test clock.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ir_shift_q <= `IR_BYPASS;
      ir_q       <= `IR_BYPASS;
      bypass_q   <= 1'h0;
    end else if (link.clk_en) begin
      if (!link.trst_n || (tck_rise && state_q == TAP_RESET)) begin
        ir_q <= `IR_BYPASS;
      end else if (tck_rise) begin
        unique case (state_q)
          TAP_CAP_IR:   ir_shift_q <= `IR_CAPTURE;
          TAP_SHIFT_IR: ir_shift_q <= {link.tdi, ir_shift_q[`IR_W-1:1]};
          TAP_UPD_IR:   ir_q <= ir_shift_q;
          TAP_CAP_DR:   bypass_q <= 1'h0;
          TAP_SHIFT_DR: bypass_q <= link.tdi;
          default:      ir_q <= ir_q;
        endcase
      end
    end
  end

  // Output stage turns on the falling edge; only shift states drive the pin.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tdo_q    <= 1'h0;
      tdo_oe_q <= 1'h0;
    end else if (link.clk_en) begin
      if (!link.trst_n) begin
        tdo_oe_q <= 1'h0;
      end else if (tck_fall) begin
        tdo_q    <= (state_q == TAP_SHIFT_IR) ? ir_shift_q[0] : bypass_q;
        tdo_oe_q <= (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);
      end
    end
  end

  assign link.tdo    = tdo_q;
  assign link.tdo_oe = tdo_oe_q;
  assign link.state  = state_q;

endmodule

`default_nettype wire

// >>> verilog/reset_strap_and_host_pins.sv
`timescale 1ns/1ps
`default_nettype none
`include "strap_pins_defs.svh"

module reset_strap_and_host_pins #(
  parameter int unsigned STRAP_SAMPLE_CYCLES = `STRAP_SAMPLE_CYCLES,
  parameter int unsigned READY_CYCLES        = `READY_CYCLES
) (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      clk_en_in,
  input  wire logic                      por_n_in,
  // General-purpose pins and their user side.
  input  wire logic [`GPIO_W-1:0]        gpio_pin_in,
  output logic      [`GPIO_W-1:0]        gpio_pin_out,
  output logic      [`GPIO_W-1:0]        gpio_pin_oe_out,
  input  wire logic [`GPIO_W-1:0]        gpio_drive_in,
  input  wire logic [`GPIO_W-1:0]        gpio_oe_req_in,
  output logic      [`GPIO_W-1:0]        gpio_level_out,
  // Serial host pins.
  input  wire logic                      sck_pin_in,
  input  wire logic                      si_pin_in,
  output logic                           si_pin_out,
  output logic                           si_pin_oe_out,
  input  wire logic                      serial_out_addr_sel_hi_in,
  output logic                           serial_out_addr_sel_hi_out,
  output logic                           serial_out_addr_sel_hi_oe_out,
  input  wire logic                      select_n_addr_sel_lo_in,
  // Serial engine side.
  input  wire logic                      spi_read_bit_in,
  input  wire logic                      spi_read_en_in,
  input  wire logic                      sda_pull_low_in,
  output logic                           spi_sck_out,
  output logic                           spi_data_out,
  output logic                           spi_select_out,
  output logic                           i2c_scl_out,
  output logic                           i2c_sda_out,
  output logic      [1:0]                i2c_addr_sel_out,
  // Strap results and readiness.
  output strap_pins_pkg::host_mode_t     host_mode_out,
  output logic      [`RATE_W-1:0]        clk_rate_sel_out,
  output logic                           straps_valid_out,
  output logic                           low_strap_fault_out,
  output logic                           device_ready_out,
  output logic                           device_reset_out,
  // Test port pins.
  input  wire logic                      tck_in,
  input  wire logic                      tms_in,
  input  wire logic                      tdi_in,
  input  wire logic                      trst_n_in,
  output logic                           tdo_out,
  output logic                           tdo_oe_out,
  output strap_pins_pkg::tap_state_t     tap_state_out
);
  import strap_pins_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [`GPIO_W-1:0]     gpio_meta_q;
  logic [`GPIO_W-1:0]     gpio_sync_q;
  logic [8:0]             pins_meta_q;
  logic [8:0]             pins_sync_q;
  logic                   por_n_s;
  logic                   sck_s;
  logic                   si_s;
  logic                   so_s;
  logic                   sel_n_s;
  logic                   tck_s;
  logic                   tms_s;
  logic                   tdi_s;
  logic                   trst_n_s;
  logic                   core_reset;

  // Two stages per pin; only the second stage is read by any logic.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gpio_meta_q <= 7'h0_000;
      gpio_sync_q <= 7'h0_000;
      pins_meta_q <= 9'h0_000;
      pins_sync_q <= 9'h0_000;
    end else if (clk_en_in) begin
      gpio_meta_q <= gpio_pin_in;
      gpio_sync_q <= gpio_meta_q;
      pins_meta_q <= {por_n_in, sck_pin_in, si_pin_in, serial_out_addr_sel_hi_in,
                      select_n_addr_sel_lo_in, tck_in, tms_in, tdi_in, trst_n_in};
      pins_sync_q <= pins_meta_q;
    end
  end

  assign {por_n_s, sck_s, si_s, so_s, sel_n_s, tck_s, tms_s, tdi_s, trst_n_s} = pins_sync_q;

  // Power-on reset pin low clears every piece of device state below.
  assign core_reset       = reset_in | ~por_n_s;
  assign device_reset_out = core_reset;

  //////////////////////////////////////////////////////////////////////////////
  // Strap window timer and latch.

  logic [`WAIT_CNT_W-1:0] wait_cnt_q;
  logic                   straps_valid_q;
  logic                   ready_q;
  host_mode_t             host_mode_q;
  logic [`RATE_W-1:0]     rate_q;
  logic                   low_fault_q;
  logic                   host_mode_strap_pin;
  logic                   low_strap_pin;

  assign host_mode_strap_pin = gpio_sync_q[`GPIO_HOST_MODE];
  assign low_strap_pin       = gpio_sync_q[`GPIO_LOW_STRAP];

  // Counts from the release of reset and stops once the ready time is reached.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      wait_cnt_q <= 25'h000_0000;
    end else if (clk_en_in && !ready_q) begin
      wait_cnt_q <= wait_cnt_q + 25'h000_0001;
    end
  end

  // Straps are caught once, early in the board's hold window, and then frozen.
  // Sampling well before the window closes leaves margin for slow pull resistors.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      straps_valid_q <= 1'h0;
      host_mode_q    <= HOST_I2C;
      rate_q         <= `RATE_RESET;
      low_fault_q    <= 1'h0;
    end else if (clk_en_in && !straps_valid_q &&
                 wait_cnt_q == `WAIT_CNT_W'(STRAP_SAMPLE_CYCLES)) begin
      straps_valid_q <= 1'h1;
      host_mode_q    <= (host_mode_strap_pin == `HOST_MODE_SPI_LEVEL) ? HOST_SPI
                                                                       : HOST_I2C;
      rate_q         <= gpio_sync_q[`GPIO_RATE_MSB:`GPIO_RATE_LSB];
      low_fault_q    <= low_strap_pin;
    end
  end

  // Ready flag rises when the full hold time has passed after reset release.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      ready_q <= 1'h0;
    end else if (clk_en_in && wait_cnt_q == `WAIT_CNT_W'(READY_CYCLES)) begin
      ready_q <= 1'h1;
    end
  end

  assign host_mode_out       = host_mode_q;
  assign clk_rate_sel_out    = rate_q;
  assign straps_valid_out    = straps_valid_q;
  assign low_strap_fault_out = low_fault_q;
  assign device_ready_out    = ready_q;

  //////////////////////////////////////////////////////////////////////////////
  // General-purpose pin drivers.

  logic [`GPIO_W-1:0] gpio_out_q;
  logic [`GPIO_W-1:0] gpio_oe_q;

  // Strap pins stay undriven until the board may release them; the other three
  // pins 2, 5 and 6 carry no strap meaning and work as plain I/O from reset on.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      gpio_out_q <= 7'h0_000;
      gpio_oe_q  <= 7'h0_000;
    end else if (clk_en_in) begin
      gpio_out_q <= gpio_drive_in;
      gpio_oe_q  <= gpio_oe_req_in & (ready_q ? 7'h0_07F : ~`STRAP_PIN_MASK);
    end
  end

  assign gpio_pin_out    = gpio_out_q;
  assign gpio_pin_oe_out = gpio_oe_q;
  assign gpio_level_out  = gpio_sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Serial host pin roles.

  logic       spi_sel_q;
  logic       spi_sck_q;
  logic       spi_data_q;
  logic       so_q;
  logic       so_oe_q;
  logic       scl_q;
  logic       sda_q;
  logic       sda_oe_q;
  logic [1:0] asel_q;
  logic       is_spi;

  // SPI routing and the SDA drive wait for the straps; I2C clock, data and address selects pass from reset on.
  assign is_spi = straps_valid_q && host_mode_q == HOST_SPI;

  // SPI role: the engine sees clock and serial input only while selected low.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      spi_sel_q  <= 1'h0;
      spi_sck_q  <= 1'h0;
      spi_data_q <= 1'h0;
    end else if (clk_en_in) begin
      spi_sel_q  <= is_spi && !sel_n_s;
      spi_sck_q  <= is_spi && !sel_n_s && sck_s;
      spi_data_q <= is_spi && !sel_n_s && si_s;
    end
  end

  // Read data leaves on the serial output, driven only while selected.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      so_q    <= 1'h0;
      so_oe_q <= 1'h0;
    end else if (clk_en_in) begin
      so_q    <= spi_read_bit_in;
      so_oe_q <= is_spi && !sel_n_s && spi_read_en_in;
    end
  end

  // I2C role: clock pin becomes SCL, serial input becomes open-drain SDA,
  // and the select and serial output pins become address selects.
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      scl_q    <= 1'h1;
      sda_q    <= 1'h1;
      sda_oe_q <= 1'h0;
      asel_q   <= 2'h0;
    end else if (clk_en_in) begin
      scl_q    <= is_spi ? 1'h1 : sck_s;
      sda_q    <= is_spi ? 1'h1 : si_s;
      sda_oe_q <= straps_valid_q && !is_spi && sda_pull_low_in;
      asel_q   <= is_spi ? 2'h0 : {so_s, sel_n_s};
    end
  end

  assign spi_select_out                = spi_sel_q;
  assign spi_sck_out                   = spi_sck_q;
  assign spi_data_out                  = spi_data_q;
  assign serial_out_addr_sel_hi_out    = so_q;
  assign serial_out_addr_sel_hi_oe_out = so_oe_q;
  assign i2c_scl_out                   = scl_q;
  assign i2c_sda_out                   = sda_q;
  assign si_pin_out                    = 1'h0; // Open drain: only ever pulls low.
  assign si_pin_oe_out                 = sda_oe_q;
  assign i2c_addr_sel_out              = asel_q;

  //////////////////////////////////////////////////////////////////////////////
  // Test access port.

  tap_link_if tap_link ();

  assign tap_link.clk_en = clk_en_in;
  assign tap_link.tck    = tck_s;
  assign tap_link.tms    = tms_s;
  assign tap_link.tdi    = tdi_s;
  assign tap_link.trst_n = trst_n_s;

  tap_controller tap_u (
    .clk_in   (clk_in),
    .reset_in (core_reset),
    .link     (tap_link)
  );

  assign tdo_out       = tap_link.tdo;
  assign tdo_oe_out    = tap_link.tdo_oe;
  assign tap_state_out = tap_link.state;

endmodule

`default_nettype wire

// >>> testbench/reset_strap_and_host_pins_assertions.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Pin-level checks on the strap and host pin block, seen from its ports only.
module reset_strap_and_host_pins_assertions
  import strap_pins_pkg::*;
(
  input wire logic                        clk_in,
  input wire logic                        device_reset_out,
  input wire logic                        select_n_addr_sel_lo_in,
  input wire logic                        spi_select_out,
  input wire logic                        spi_data_out,
  input wire logic                        serial_out_addr_sel_hi_oe_out,
  input wire logic                        serial_out_addr_sel_hi_out,
  input wire logic                        serial_out_addr_sel_hi_in,
  input wire logic                        spi_read_en_in,
  input wire logic                        spi_read_bit_in,
  input wire strap_pins_pkg::host_mode_t  host_mode_out,
  input wire logic [1:0]                  clk_rate_sel_out,
  input wire logic                        straps_valid_out,
  input wire logic                        i2c_scl_out,
  input wire logic                        i2c_sda_out,
  input wire logic [1:0]                  i2c_addr_sel_out,
  input wire logic                        sck_pin_in,
  input wire logic                        si_pin_in,
  input wire logic                        tdo_oe_out,
  input wire strap_pins_pkg::tap_state_t  tap_state_out,
  input wire logic                        trst_n_in,
  input wire logic                        device_ready_out,
  input wire logic [6:0]                  gpio_pin_oe_out
);
  // The device reset covers both the reset input and the synced power-on pin.
  default clocking @(posedge clk_in); endclocking
  default disable iff (device_reset_out);

  // Four samples cover the two synchroniser stages and the output register.
  sequence sel_idle;
    select_n_addr_sel_lo_in [*4];
  endsequence
  sequence trst_held;
    !trst_n_in [*4];
  endsequence

  a_spi_select_gate: assert property (sel_idle |-> !spi_select_out && !serial_out_addr_sel_hi_oe_out)
    else $error("serial port active with select high");
  a_straps_kept: assert property (straps_valid_out |=> straps_valid_out && $stable(host_mode_out) && $stable(clk_rate_sel_out))
    else $error("strap results changed before reset");
  a_i2c_pin_map: assert property (straps_valid_out && host_mode_out == HOST_I2C |->
    i2c_scl_out == $past(sck_pin_in, 3) && i2c_sda_out == $past(si_pin_in, 3) &&
    i2c_addr_sel_out == {$past(serial_out_addr_sel_hi_in, 3), $past(select_n_addr_sel_lo_in, 3)})
    else $error("two-wire pins not mapped");
  // The routing register lags the strap latch by one cycle, so the first valid cycle is skipped.
  a_spi_data_map: assert property (straps_valid_out && $past(straps_valid_out) &&
    host_mode_out == HOST_SPI && !$past(select_n_addr_sel_lo_in, 3) |->
    spi_select_out && spi_data_out == $past(si_pin_in, 3))
    else $error("serial input not passed while selected");
  a_so_read_drive: assert property (serial_out_addr_sel_hi_oe_out |-> host_mode_out == HOST_SPI &&
    $past(spi_read_en_in) && serial_out_addr_sel_hi_out == $past(spi_read_bit_in))
    else $error("serial output driven without a read");
  a_tdo_float: assert property ($rose(tdo_oe_out) |-> tap_state_out inside {TAP_SHIFT_IR, TAP_SHIFT_DR})
    else $error("test output enabled outside a shift");
  a_trst_force: assert property (trst_held |-> tap_state_out == TAP_RESET && !tdo_oe_out)
    else $error("test reset did not force reset state");
  a_strap_pin_gate: assert property (!device_ready_out |-> (gpio_pin_oe_out & 7'h1B) == 7'h00)
    else $error("strap pin driven before ready");
endmodule

bind reset_strap_and_host_pins reset_strap_and_host_pins_assertions reset_strap_and_host_pins_assertions_i (
  .clk_in, .device_reset_out, .select_n_addr_sel_lo_in, .spi_select_out, .spi_data_out,
  .serial_out_addr_sel_hi_oe_out, .serial_out_addr_sel_hi_out, .serial_out_addr_sel_hi_in,
  .spi_read_en_in, .spi_read_bit_in, .host_mode_out, .clk_rate_sel_out, .straps_valid_out,
  .i2c_scl_out, .i2c_sda_out, .i2c_addr_sel_out, .sck_pin_in, .si_pin_in, .tdo_oe_out,
  .tap_state_out, .trst_n_in, .device_ready_out, .gpio_pin_oe_out
);

`default_nettype wire

// >>> testbench/board_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Board around the device: strap drivers, pin pulls and the test port driver.
module board_model (
  input  wire logic [6:0] strap_in,
  input  wire logic       hold_in,
  input  wire logic [6:0] dev_drive_in,
  input  wire logic [6:0] dev_oe_in,
  input  wire logic       tdo_in,
  input  wire logic       tdo_oe_in,
  output logic      [6:0] gpio_out,
  output logic            tck_out,
  output logic            tms_out,
  output logic            tdi_out
);
  // Released pins fall to their pulls: 0 to 5 down, 6 up, never the old level.
  assign gpio_out = (dev_oe_in & dev_drive_in) | (~dev_oe_in & (hold_in ? strap_in : 7'h40));

  // The test clock stands low between frames; data lines idle at their pull-ups.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // One 80 ns test clock period; the output is sampled late in the low phase.
  task automatic step(input logic m, input logic d, output logic [1:0] seen);
    tms_out = m;
    tdi_out = d;
    #20;
    tck_out = 1'b1;
    #40;
    tck_out = 1'b0;
    #20;
    seen = {tdo_oe_in, tdo_in};
  endtask
endmodule

`default_nettype wire

// >>> testbench/reset_strap_and_host_pins_test.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module reset_strap_and_host_pins_test;
  import strap_pins_pkg::*;
  logic       clk_in, reset_in, clk_en_in, por_n_in, hold, trst_n_in;
  logic [6:0] strap, gpio_pin_in, gpio_pin_out, gpio_pin_oe_out, gpio_drive_in;
  logic [6:0] gpio_oe_req_in, gpio_level_out;
  logic       sck_pin_in, si_pin_in, si_pin_out, si_pin_oe_out, serial_out_addr_sel_hi_in;
  logic       serial_out_addr_sel_hi_out, serial_out_addr_sel_hi_oe_out, select_n_addr_sel_lo_in;
  logic       spi_read_bit_in, spi_read_en_in, sda_pull_low_in, spi_sck_out, spi_data_out;
  logic       spi_select_out, i2c_scl_out, i2c_sda_out, straps_valid_out, low_strap_fault_out;
  logic       device_ready_out, device_reset_out, tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out;
  logic [1:0] i2c_addr_sel_out, clk_rate_sel_out, seen;
  host_mode_t host_mode_out;
  tap_state_t tap_state_out;
  logic [3:0] notes[$];
  int         miscompares, checked;

  // Short counts keep the run brief; sampling sits at a fifth of the ready time here, a 125th by default.
  reset_strap_and_host_pins #(.STRAP_SAMPLE_CYCLES(20), .READY_CYCLES(100))
  reset_strap_and_host_pins_i (
    .clk_in, .reset_in, .clk_en_in, .por_n_in, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_out,
    .gpio_drive_in, .gpio_oe_req_in, .gpio_level_out, .sck_pin_in, .si_pin_in, .si_pin_out,
    .si_pin_oe_out, .serial_out_addr_sel_hi_in, .serial_out_addr_sel_hi_out,
    .serial_out_addr_sel_hi_oe_out, .select_n_addr_sel_lo_in, .spi_read_bit_in, .spi_read_en_in,
    .sda_pull_low_in, .spi_sck_out, .spi_data_out, .spi_select_out, .i2c_scl_out, .i2c_sda_out,
    .i2c_addr_sel_out, .host_mode_out, .clk_rate_sel_out, .straps_valid_out, .low_strap_fault_out,
    .device_ready_out, .device_reset_out, .tck_in, .tms_in, .tdi_in, .trst_n_in, .tdo_out,
    .tdo_oe_out, .tap_state_out
  );
  board_model board_model_i (
    .strap_in(strap), .hold_in(hold), .dev_drive_in(gpio_pin_out), .dev_oe_in(gpio_pin_oe_out),
    .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out), .gpio_out(gpio_pin_in), .tck_out(tck_in),
    .tms_out(tms_in), .tdi_out(tdi_in)
  );

  // A 5 ns clock.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Every wait is bounded so a stuck flag ends the run instead of hanging it.
  task automatic wait_hi(input bit rdy, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((rdy ? device_ready_out : straps_valid_out) === 1'b1) break;
      @(negedge clk_in);
    end
    if (i == lim) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // Each strap result is matched against the oldest note left by the driver.
  always @(posedge straps_valid_out) begin
    #1;
    if (notes.size() == 0) check(8'h00, 8'hFF);
    else check({4'h0, host_mode_out, clk_rate_sel_out, low_strap_fault_out}, {4'h0, notes.pop_front()});
  end

  // Main sequence: every mode and rate code, both reset sources, then the test port.
  initial begin
    logic [31:0] r;
    logic [8:0]  walk;
    {reset_in, clk_en_in, por_n_in, hold, trst_n_in} = 5'h1E;
    {strap, gpio_drive_in, gpio_oe_req_in} = {14'h0000, 7'h7F};
    {sck_pin_in, si_pin_in, serial_out_addr_sel_hi_in, select_n_addr_sel_lo_in} = 4'hF;
    {spi_read_bit_in, spi_read_en_in, sda_pull_low_in} = 3'h0;
    {miscompares, checked} = {32'h0000_0000, 32'h0000_0000};
    r = $urandom(32'haf98a1f8);
    cyc(2);
    {reset_in, trst_n_in} = 2'h1;
    for (int k = 0; k < 8; k++) begin
      r = $urandom();
      strap = {r[6:5], k == 5, k[2], r[2], k[1:0]};
      notes.push_back({k[2], k[1:0], k == 5});
      hold = 1'b1;
      if (k[0]) begin
        por_n_in = 1'b0;
        cyc(4);
        check({7'h00, device_reset_out}, 8'h01);
        por_n_in = 1'b1;
      end else begin
        reset_in = 1'b1;
        cyc(2);
        reset_in = 1'b0;
      end
      wait_hi(1'b0, 60);
      check({1'b0, gpio_pin_oe_out}, 8'h64);
      // Random host pin traffic in whichever personality the straps chose.
      repeat (4) begin
        r = $urandom();
        {sck_pin_in, si_pin_in, serial_out_addr_sel_hi_in, select_n_addr_sel_lo_in} = r[3:0];
        {spi_read_bit_in, spi_read_en_in, sda_pull_low_in} = r[6:4];
        gpio_drive_in = r[13:7];
        cyc(4);
        if (k[2]) check({3'h0, spi_select_out, spi_sck_out, spi_data_out, serial_out_addr_sel_hi_oe_out,
          serial_out_addr_sel_hi_out & serial_out_addr_sel_hi_oe_out},
          r[0] ? 8'h00 : {3'h0, 1'b1, r[3], r[2], r[5], r[6] & r[5]});
        else check({2'h0, spi_select_out, i2c_scl_out, i2c_sda_out, i2c_addr_sel_out, si_pin_oe_out},
          {3'h0, r[3], r[2], r[1], r[0], r[4]});
      end
      wait_hi(1'b1, 200);
      check({6'h00, straps_valid_out, device_ready_out}, 8'h03);
      hold = 1'b0;
      // Enough cycles for the widened enables to come back through the pin synchronisers.
      cyc(4);
      check({gpio_pin_oe_out, 1'b0}, 8'hFE);
      check({1'b0, gpio_pin_out}, {1'b0, gpio_drive_in});
      check({1'b0, gpio_level_out}, {1'b0, gpio_drive_in});
    end
    // Clock enable low must freeze the registered drive value until it returns.
    clk_en_in = 1'b0;
    gpio_drive_in = ~gpio_drive_in;
    cyc(4);
    check({1'b0, gpio_pin_out}, {1'b0, ~gpio_drive_in});
    clk_en_in = 1'b1;
    cyc(2);
    check({1'b0, gpio_pin_out}, {1'b0, gpio_drive_in});
    // Load the capture value into the instruction register and shift it out.
    walk = 9'h106;
    for (int i = 0; i < 9; i++) begin
      board_model_i.step(walk[i], r[i + 9], seen);
      if (i > 3) check({6'h00, seen[1], seen[0] & (i < 8)}, {6'h00, i < 8, i == 4});
    end
    trst_n_in = 1'b0;
    cyc(5);
    check({4'h0, tap_state_out}, {4'h0, TAP_RESET});
    wrap_up();
  end
endmodule

`default_nettype wire
